// ### hdl/tmr_pkg.sv
// How it works
// - Toggle mode counts to compare A, then zero.
// - Toggle mode inverts output on compare A match.
// - Toggle frequency is clock over 2N(A+1).
// - Single-slope counts zero to top, repeats.
// - Single-slope sets on match, clears at top.
// - Top limit sets resolution, 2 to 16 bits.
// - Single-slope frequency is clock over N(top+1).
// - Dual-slope counts up to top, down to zero.
// - Dual-slope sets at zero, match clears/sets by direction.
// - Dual-slope frequency is clock over 2N top.
// - Enabled channel in wave mode overrides pin latch.
// - Pin invert drives inverted waveform output.
// - Wrap, per-channel and capture overrun interrupts.
// - Every interrupt condition also emits an event.
// - Wrap request acked by DMA count/top writes.
// - Channel request acked by DMA value/buffer access.
// - Software update acts like hardware, unless locked.
// - Restart zeroes counter, direction and outputs.
// - Reset command restores registers, only when off or on an event clock.
// - Mode select picks normal, toggle, single, dual.
// - Compare match sets channel flag one clock later.
// - Buffers copy to active at update point or on software update.
package tmr_pkg;
   localparam int          DATA_W    = 16;
   localparam int          ADDR_W    = 4;
   localparam int          CH_N      = 4;
   localparam int          PRE_W     = 10;
   localparam logic [3:0]  OFS_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_CMD   = 4'h1;
   localparam logic [3:0]  OFS_AUX   = 4'h2;
   localparam logic [3:0]  OFS_FLAGS = 4'h3;
   localparam logic [3:0]  OFS_COUNT = 4'h4;
   localparam logic [3:0]  OFS_TOP   = 4'h5;
   localparam logic [3:0]  OFS_TOPB  = 4'h6;
   localparam logic [3:0]  OFS_CMP   = 4'h7;
   localparam logic [3:0]  OFS_CMPB  = 4'hb;
   localparam int          CLK_LSB   = 0;
   localparam int          CLK_EVT   = 3;
   localparam int          MODE_LSB  = 4;
   localparam int          CAPT_BIT  = 7;
   localparam int          EN_LSB    = 8;
   localparam int          INV_LSB   = 12;
   localparam int          CMD_UPD   = 0;
   localparam int          CMD_RSTRT = 1;
   localparam int          CMD_RESET = 2;
   localparam int          LOCK_BIT  = 0;
   localparam int          CMPO_LSB  = 4;
   localparam int          F_WRAP    = 0;
   localparam int          F_UNDER   = 1;
   localparam int          F_ERR     = 2;
   localparam int          F_DIR     = 3;
   localparam int          F_CH_LSB  = 4;
   localparam logic [3:0]  CLK_OFF   = 4'h0;
   localparam logic [2:0]  MODE_NORM = 3'h0;
   localparam logic [2:0]  MODE_TOGL = 3'h1;
   localparam logic [2:0]  MODE_SGL  = 3'h3;
   localparam logic [2:0]  MODE_DTOP = 3'h5;
   localparam logic [2:0]  MODE_DBTH = 3'h6;
   localparam logic [2:0]  MODE_DBOT = 3'h7;
   localparam logic [15:0] TOP_RST   = 16'hffff;
   // Prescaler terminal counts indexed by clock select; select zero is off.
   localparam logic [7:0][PRE_W-1:0] PRE_LIM = {10'h3ff, 10'h0ff, 10'h03f,
      10'h007, 10'h003, 10'h001, 10'h000, 10'h000};

   typedef enum logic {DIR_UP, DIR_DOWN} dir_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
      logic              dma;
   } bus_req_type;

   typedef struct packed {
      logic            wrap;
      logic            under;
      logic            err;
      logic [CH_N-1:0] ch;
   } flag_type;

   typedef struct packed {
      logic [3:0]                   clksel;
      logic [2:0]                   mode;
      logic                         capt;
      logic [CH_N-1:0]              en;
      logic [CH_N-1:0]              inv;
      logic                         lock;
      logic [PRE_W-1:0]             pre;
      logic [DATA_W-1:0]            count;
      dir_type                      dir;
      logic [DATA_W-1:0]            top;
      logic [DATA_W-1:0]            top_buf;
      logic                         top_bv;
      logic [CH_N-1:0][DATA_W-1:0]  cmp;
      logic [CH_N-1:0][DATA_W-1:0]  cmp_buf;
      logic [CH_N-1:0]              cmp_bv;
      logic [CH_N-1:0]              wg;
      flag_type                     flag;
      flag_type                     evt;
      logic [CH_N-1:0]              pin;
      logic [CH_N-1:0]              ovr;
      logic [DATA_W-1:0]            rdata;
   } state_type;
endpackage

// ### hdl/timer_waveform_generator.sv
`timescale 1ns/1ps
module timer_waveform_generator (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire tmr_pkg::bus_req_type  bus,
   output logic [tmr_pkg::DATA_W-1:0] rdata,
   input  wire logic [tmr_pkg::CH_N-1:0] pin_latch,
   input  wire logic                  capture_overrun,
   output logic [tmr_pkg::CH_N-1:0]   pin_value,
   output logic [tmr_pkg::CH_N-1:0]   pin_override,
   output tmr_pkg::flag_type          req,
   output tmr_pkg::flag_type          evt
);

   tmr_pkg::state_type s_q;
   tmr_pkg::state_type s_d;

   logic                         running;
   logic                         tick;
   logic                         dual;
   logic [tmr_pkg::DATA_W-1:0]   period;
   logic                         cmd_w;
   logic                         sw_upd;
   logic                         sw_rst;
   logic                         sw_reset;
   logic                         hit_top;
   logic                         hit_bot;
   logic                         upd_pt;
   logic                         wrap_set;
   logic [tmr_pkg::CH_N-1:0]     ch_set;
   logic [tmr_pkg::CH_N-1:0]     ch_clr;
   logic                         wrap_clr;
   logic                         under_clr;
   logic                         err_clr;
   logic                         err_set;

   // Event clock sources are outside this block and leave the counter idle.
   function automatic logic [tmr_pkg::PRE_W-1:0] pre_limit(
      input logic [3:0] sel);
      pre_limit = sel[tmr_pkg::CLK_EVT] ? '0 : tmr_pkg::PRE_LIM[sel[2:0]];
   endfunction

   function automatic tmr_pkg::state_type rst_state();
      tmr_pkg::state_type r;
      r         = '0;
      r.top     = tmr_pkg::TOP_RST;
      r.top_buf = tmr_pkg::TOP_RST;
      r.dir     = tmr_pkg::DIR_UP;
      rst_state = r;
   endfunction

   function automatic logic is_dual(input logic [2:0] m);
      is_dual = (m == tmr_pkg::MODE_DTOP) || (m == tmr_pkg::MODE_DBTH) ||
                (m == tmr_pkg::MODE_DBOT);
   endfunction

   assign running  = (s_q.clksel != tmr_pkg::CLK_OFF) &&
                     !s_q.clksel[tmr_pkg::CLK_EVT];
   assign tick     = running && (s_q.pre == pre_limit(s_q.clksel));
   assign dual     = is_dual(s_q.mode);
   assign period   = (s_q.mode == tmr_pkg::MODE_TOGL) ? s_q.cmp[0]
                                                       : s_q.top;
   assign cmd_w    = bus.wr && (bus.addr == tmr_pkg::OFS_CMD);
   assign sw_upd   = cmd_w && bus.wdata[tmr_pkg::CMD_UPD] && !s_q.lock;
   assign sw_rst   = cmd_w && bus.wdata[tmr_pkg::CMD_RSTRT];
   assign sw_reset = cmd_w && bus.wdata[tmr_pkg::CMD_RESET] && !running;

   always_comb begin
      s_d       = s_q;
      s_d.evt   = '0;
      hit_top   = 1'b0;
      hit_bot   = 1'b0;
      ch_set    = '0;
      ch_clr    = '0;
      wrap_clr  = 1'b0;
      under_clr = 1'b0;
      err_clr   = 1'b0;
      s_d.pre   = (tick || !running) ? '0 : s_q.pre + 10'h001;
      // Counting sequence, one step per prescaled tick.
      if (tick) begin
         if (dual) begin
            if (s_q.dir == tmr_pkg::DIR_UP) begin
               if (s_q.count >= s_q.top) begin
                  s_d.dir   = tmr_pkg::DIR_DOWN;
                  s_d.count = s_q.count - 16'h0001;
                  hit_top   = 1'b1;
               end else begin
                  s_d.count = s_q.count + 16'h0001;
               end
            end else if (s_q.count == '0) begin
               s_d.dir   = tmr_pkg::DIR_UP;
               s_d.count = 16'h0001;
               hit_bot   = 1'b1;
            end else begin
               s_d.count = s_q.count - 16'h0001;
            end
         end else if (s_q.count == period) begin
            s_d.count = '0;
            hit_top   = 1'b1;
         end else begin
            s_d.count = s_q.count + 16'h0001;
         end
         for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            ch_set[i] = (s_q.count == s_q.cmp[i]);
            case (s_q.mode)
               tmr_pkg::MODE_TOGL: begin
                  if (i == 0 && ch_set[i]) begin
                     s_d.wg[i] = ~s_q.wg[i];
                  end
               end
               tmr_pkg::MODE_SGL: begin
                  if (s_q.count == s_q.top) begin
                     s_d.wg[i] = 1'b0;
                  end else if (ch_set[i]) begin
                     s_d.wg[i] = 1'b1;
                  end
               end
               tmr_pkg::MODE_DTOP, tmr_pkg::MODE_DBTH,
               tmr_pkg::MODE_DBOT: begin
                  if (s_q.count == '0) begin
                     s_d.wg[i] = 1'b1;
                  end else if (ch_set[i]) begin
                     s_d.wg[i] = (s_q.dir == tmr_pkg::DIR_DOWN);
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Where the wrap flag fires and where buffers load depend on mode.
      case (s_q.mode)
         tmr_pkg::MODE_DTOP: wrap_set = hit_top;
         tmr_pkg::MODE_DBTH: wrap_set = hit_top || hit_bot;
         tmr_pkg::MODE_DBOT: wrap_set = hit_bot;
         default:            wrap_set = hit_top;
      endcase
      upd_pt = dual ? hit_bot : hit_top;
      if (upd_pt || sw_upd) begin
         if (s_q.top_bv) begin
            s_d.top    = s_q.top_buf;
            s_d.top_bv = 1'b0;
         end
         for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            if (s_q.cmp_bv[i]) begin
               s_d.cmp[i]    = s_q.cmp_buf[i];
               s_d.cmp_bv[i] = 1'b0;
            end
         end
      end
      // A bus write wins over the counting step in the same cycle.
      if (bus.wr) begin
         case (bus.addr)
            tmr_pkg::OFS_CTRL: begin
               s_d.clksel = bus.wdata[tmr_pkg::CLK_LSB +: 4];
               s_d.mode   = bus.wdata[tmr_pkg::MODE_LSB +: 3];
               s_d.capt   = bus.wdata[tmr_pkg::CAPT_BIT];
               s_d.en     = bus.wdata[tmr_pkg::EN_LSB +: tmr_pkg::CH_N];
               s_d.inv    = bus.wdata[tmr_pkg::INV_LSB +: tmr_pkg::CH_N];
            end
            tmr_pkg::OFS_AUX: begin
               s_d.lock = bus.wdata[tmr_pkg::LOCK_BIT];
               if (!running) begin
                  s_d.wg = bus.wdata[tmr_pkg::CMPO_LSB +: tmr_pkg::CH_N];
               end
            end
            tmr_pkg::OFS_FLAGS: begin
               wrap_clr  = bus.wdata[tmr_pkg::F_WRAP];
               under_clr = bus.wdata[tmr_pkg::F_UNDER];
               err_clr   = bus.wdata[tmr_pkg::F_ERR];
               ch_clr    = bus.wdata[tmr_pkg::F_CH_LSB +: tmr_pkg::CH_N];
            end
            tmr_pkg::OFS_COUNT: s_d.count = bus.wdata;
            tmr_pkg::OFS_TOP:   s_d.top = bus.wdata;
            tmr_pkg::OFS_TOPB: begin
               s_d.top_buf = bus.wdata;
               s_d.top_bv  = 1'b1;
            end
            default: begin
            end
         endcase
         for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            if (bus.addr == tmr_pkg::OFS_CMP + 4'(i)) begin
               s_d.cmp[i] = bus.wdata;
            end
            if (bus.addr == tmr_pkg::OFS_CMPB + 4'(i)) begin
               s_d.cmp_buf[i] = bus.wdata;
               s_d.cmp_bv[i]  = 1'b1;
            end
         end
         if (bus.dma && (bus.addr == tmr_pkg::OFS_COUNT ||
                         bus.addr == tmr_pkg::OFS_TOP ||
                         bus.addr == tmr_pkg::OFS_TOPB)) begin
            wrap_clr  = 1'b1;
            under_clr = 1'b1;
         end
      end
      if (bus.dma && (bus.wr || bus.rd)) begin
         for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            if (s_q.capt ? (bus.addr == tmr_pkg::OFS_CMP + 4'(i))
                         : (bus.addr == tmr_pkg::OFS_CMPB + 4'(i))) begin
               ch_clr[i] = 1'b1;
            end
         end
      end
      if (sw_rst) begin
         s_d.count = '0;
         s_d.dir   = tmr_pkg::DIR_UP;
         s_d.wg    = '0;
      end
      // Capture overrun only counts while the channels are in capture use.
      err_set = capture_overrun && s_q.capt;
      // A hardware set in the same cycle as a clear keeps the flag up.
      s_d.flag.wrap  = (s_q.flag.wrap & ~wrap_clr) | wrap_set;
      s_d.flag.under = (s_q.flag.under & ~under_clr) | (hit_bot && dual);
      s_d.flag.err   = (s_q.flag.err & ~err_clr) | err_set;
      s_d.flag.ch    = (s_q.flag.ch & ~ch_clr) | ch_set;
      s_d.evt.wrap   = wrap_set;
      s_d.evt.under  = hit_bot && dual;
      s_d.evt.err    = err_set;
      s_d.evt.ch     = ch_set;
      if (sw_reset) begin
         s_d = rst_state();
      end
      for (int i = 0; i < tmr_pkg::CH_N; i++) begin
         s_d.ovr[i] = s_d.en[i] && (s_d.mode != tmr_pkg::MODE_NORM);
         s_d.pin[i] = s_d.ovr[i] ? (s_d.wg[i] ^ s_d.inv[i])
                                 : pin_latch[i];
      end
      s_d.rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            tmr_pkg::OFS_CTRL: begin
               s_d.rdata[tmr_pkg::CLK_LSB +: 4]  = s_q.clksel;
               s_d.rdata[tmr_pkg::MODE_LSB +: 3] = s_q.mode;
               s_d.rdata[tmr_pkg::CAPT_BIT]      = s_q.capt;
               s_d.rdata[tmr_pkg::EN_LSB +: tmr_pkg::CH_N]  = s_q.en;
               s_d.rdata[tmr_pkg::INV_LSB +: tmr_pkg::CH_N] = s_q.inv;
            end
            tmr_pkg::OFS_AUX: begin
               s_d.rdata[tmr_pkg::LOCK_BIT]                  = s_q.lock;
               s_d.rdata[tmr_pkg::CMPO_LSB +: tmr_pkg::CH_N] = s_q.wg;
            end
            tmr_pkg::OFS_FLAGS: begin
               s_d.rdata[tmr_pkg::F_WRAP]  = s_q.flag.wrap;
               s_d.rdata[tmr_pkg::F_UNDER] = s_q.flag.under;
               s_d.rdata[tmr_pkg::F_ERR]   = s_q.flag.err;
               s_d.rdata[tmr_pkg::F_DIR]   = (s_q.dir == tmr_pkg::DIR_DOWN);
               s_d.rdata[tmr_pkg::F_CH_LSB +: tmr_pkg::CH_N] = s_q.flag.ch;
            end
            tmr_pkg::OFS_COUNT: s_d.rdata = s_q.count;
            tmr_pkg::OFS_TOP:   s_d.rdata = s_q.top;
            tmr_pkg::OFS_TOPB:  s_d.rdata = s_q.top_buf;
            default: begin
            end
         endcase
         for (int i = 0; i < tmr_pkg::CH_N; i++) begin
            if (bus.addr == tmr_pkg::OFS_CMP + 4'(i)) begin
               s_d.rdata = s_q.cmp[i];
            end
            if (bus.addr == tmr_pkg::OFS_CMPB + 4'(i)) begin
               s_d.rdata = s_q.cmp_buf[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q <= rst_state();
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata        = s_q.rdata;
   assign pin_value    = s_q.pin;
   assign pin_override = s_q.ovr;
   assign req          = s_q.flag;
   assign evt          = s_q.evt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_quiet_tick;
      tick && !bus.wr;
   endsequence

   sequence s_toggle_hit;
      s_quiet_tick ##0 (s_q.mode == tmr_pkg::MODE_TOGL) &&
      (s_q.count == s_q.cmp[0]);
   endsequence

   sequence s_single_top;
      s_quiet_tick ##0 (s_q.mode == tmr_pkg::MODE_SGL) &&
      (s_q.count == s_q.top);
   endsequence

   a_toggle_flip: assert property (s_toggle_hit |=>
      s_q.wg[0] != $past(s_q.wg[0]))
      else $error("Toggle output did not invert on match.");

   a_toggle_wrap: assert property (s_toggle_hit |=>
      s_q.count == '0)
      else $error("Toggle counter did not restart after match.");

   a_single_top: assert property (s_single_top |=>
      (s_q.count == '0) && (s_q.wg == '0))
      else $error("Single-slope top did not wrap and clear outputs.");

   a_dual_turn: assert property (s_quiet_tick ##0 dual &&
      (s_q.dir == tmr_pkg::DIR_UP) && (s_q.count == s_q.top) &&
      (s_q.top != '0) |=> (s_q.dir == tmr_pkg::DIR_DOWN) &&
      (s_q.count == $past(s_q.top) - 16'h0001))
      else $error("Dual-slope did not turn down at top.");

   a_restart_zero: assert property (sw_rst |=>
      (s_q.count == '0) && (s_q.dir == tmr_pkg::DIR_UP) &&
      (s_q.wg == '0))
      else $error("Restart left counter or outputs nonzero.");

   a_reset_gated: assert property (cmd_w &&
      bus.wdata[tmr_pkg::CMD_RESET] && running |=> $stable(s_q.clksel))
      else $error("Reset command acted while running.");

   a_update_lock: assert property (cmd_w && bus.wdata[tmr_pkg::CMD_UPD] &&
      s_q.lock && !tick |=> $stable(s_q.top))
      else $error("Locked update changed the top limit.");

   a_flag_next: assert property (tick && (s_q.count == s_q.cmp[1]) |=>
      s_q.flag.ch[1] && s_q.evt.ch[1])
      else $error("Channel flag not set after compare match.");

   a_pin_drive: assert property (s_q.ovr[0] |->
      s_q.pin[0] == (s_q.wg[0] ^ s_q.inv[0]))
      else $error("Overridden pin does not follow waveform.");

   a_dma_ack: assert property (bus.wr && bus.dma &&
      (bus.addr == tmr_pkg::OFS_COUNT) && !tick |=> !s_q.flag.wrap)
      else $error("DMA count write did not clear wrap flag.");

   sequence s_dual_bottom;
      s_quiet_tick ##0 dual && (s_q.dir == tmr_pkg::DIR_DOWN) &&
      (s_q.count == '0);
   endsequence

   a_dual_rise: assert property (s_dual_bottom |=>
      (s_q.dir == tmr_pkg::DIR_UP) && (s_q.count == 16'h0001) &&
      (s_q.wg == '1) && s_q.flag.under)
      else $error("Dual-slope did not turn up at zero.");

   a_single_set: assert property (s_quiet_tick ##0
      (s_q.mode == tmr_pkg::MODE_SGL) && (s_q.count == s_q.cmp[1]) &&
      (s_q.count != s_q.top) |=> s_q.wg[1])
      else $error("Single-slope output not set on match.");

   a_dual_match: assert property (s_quiet_tick ##0 dual &&
      (s_q.count == s_q.cmp[2]) && (s_q.count != '0) |=>
      s_q.wg[2] == ($past(s_q.dir) == tmr_pkg::DIR_DOWN))
      else $error("Dual-slope match drove the wrong level.");

   a_err_flag: assert property (capture_overrun && s_q.capt &&
      !sw_reset |=> s_q.flag.err && s_q.evt.err)
      else $error("Capture overrun did not raise the error flag.");

   a_pin_latch: assert property (!s_q.ovr[1] && $past(nrst) |->
      s_q.pin[1] == $past(pin_latch[1]))
      else $error("Released pin does not follow its latch.");

   a_evt_flag: assert property (s_q.evt != '0 |->
      (s_q.evt & ~s_q.flag) == '0)
      else $error("Event raised without its flag.");

endmodule

// ### tb/tmr_far_side.sv
`timescale 1ns/1ps
module tmr_far_side (
   input  wire logic                     clk,
   input  wire logic [tmr_pkg::CH_N-1:0] latch_set,
   input  wire logic                     overrun_kick,
   input  wire tmr_pkg::flag_type        evt,
   output logic [tmr_pkg::CH_N-1:0]      pin_latch,
   output logic                          capture_overrun,
   output int                            ch_evt_cnt,
   output int                            err_evt_cnt
);
   // The capture path can only report a full buffer as a single pulse.
   assign pin_latch       = latch_set;
   assign capture_overrun = overrun_kick;
   // The event system only counts pulses; it never stalls the source.
   always @(posedge clk) begin
      if (evt.ch[0] === 1'b1)
         ch_evt_cnt <= ch_evt_cnt + 1;
      if (evt.err === 1'b1)
         err_evt_cnt <= err_evt_cnt + 1;
   end
endmodule

// ### tb/timer_waveform_generator_test.sv
`timescale 1ns/1ps
module timer_waveform_generator_test;
   logic                 clk;
   logic                 nrst;
   tmr_pkg::bus_req_type bus;
   logic [15:0]          rdata;
   logic [3:0]           lat;
   logic [3:0]           pin_latch;
   logic [3:0]           pin_value;
   logic [3:0]           pin_override;
   logic                 kick;
   logic                 capture_overrun;
   tmr_pkg::flag_type    req;
   tmr_pkg::flag_type    evt;
   int                   ch_evt_cnt;
   int                   err_evt_cnt;
   int                   error_cnt;
   int                   check_count;
   int                   cyc;
   logic [31:0]          seed;

   timer_waveform_generator dut_u (.clk(clk), .nrst(nrst), .bus(bus),
      .rdata(rdata), .pin_latch(pin_latch),
      .capture_overrun(capture_overrun), .pin_value(pin_value),
      .pin_override(pin_override), .req(req), .evt(evt));

   tmr_far_side far_u (.clk(clk), .latch_set(lat), .overrun_kick(kick),
      .evt(evt), .pin_latch(pin_latch),
      .capture_overrun(capture_overrun), .ch_evt_cnt(ch_evt_cnt),
      .err_evt_cnt(err_evt_cnt));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [15:0] ctrl(input logic [3:0] sel,
      input logic [2:0] mode, input logic [3:0] en, input logic [3:0] inv);
      return {inv, en, 1'b0, mode, sel};
   endfunction

   // Prescaler ratio of each running clock select.
   function automatic int ratio(input logic [3:0] sel);
      int tbl[8] = '{0, 1, 2, 4, 8, 64, 256, 1024};
      return tbl[sel[2:0]];
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d,
      input logic dm = 1'b0);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, dma: dm};
      @(posedge clk);
      bus.wr  <= 1'b0;
      bus.dma <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, dma: 1'b0};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   // A clean start: stop, restart the period, load limits, then run.
   task automatic start(input logic [3:0] sel, input logic [2:0] mode,
      input int ch, input logic [15:0] top, input logic [15:0] cmp);
      wr(tmr_pkg::OFS_CTRL, ctrl(4'h0, mode, 4'h0, 4'h0));
      wr(tmr_pkg::OFS_CMD, 16'h0002);
      wr(tmr_pkg::OFS_TOP, top);
      wr(tmr_pkg::OFS_CMP + 4'(ch), cmp);
      wr(tmr_pkg::OFS_CTRL, ctrl(sel, mode, 4'(1 << ch), 4'h0));
   endtask

   // Rise-to-rise time of a pin, skipping the first partial period.
   task automatic measure(input int ch, input int exp);
      int   t[$];
      int   n;
      logic p;
      n = 0;
      p = pin_value[ch];
      while (t.size() < 3 && n < 8000) begin
         @(posedge clk);
         #1;
         n++;
         if (!p && pin_value[ch])
            t.push_back(cyc);
         p = pin_value[ch];
      end
      if (t.size() < 3) begin
         error_cnt++;
         $display("unexpected at %0t: no waveform on pin %0d", $time, ch);
         results();
      end
      check(16'(t[2] - t[1]), 16'(exp));
   endtask

   logic [3:0]           sel_t[3] = '{4'h1, 4'h1, 4'h3};
   logic [15:0]          a_t[3] = '{16'h0000, 16'h0003, 16'h0002};
   logic [2:0]           mode_t[3] = '{tmr_pkg::MODE_DTOP,
                            tmr_pkg::MODE_DBTH, tmr_pkg::MODE_DBOT};

   initial begin
      nrst        = 1'b0;
      bus         = '0;
      lat         = 4'h0;
      kick        = 1'b0;
      error_cnt   = 0;
      check_count = 0;
      seed        = 32'h76b2577e;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(tmr_pkg::OFS_TOP, 16'hffff);
      rd_chk(tmr_pkg::OFS_COUNT, 16'h0000);
      rd_chk(4'hf, 16'h0000);
      $display("test reset done");

      wr(tmr_pkg::OFS_CTRL, ctrl(4'h0, tmr_pkg::MODE_TOGL, 4'hf, 4'h3));
      wr(tmr_pkg::OFS_AUX, 16'h0050);
      @(posedge clk);
      #1;
      check({12'h000, pin_override}, 16'h000f);
      check({12'h000, pin_value}, 16'h0006);
      wr(tmr_pkg::OFS_CTRL, ctrl(4'h0, tmr_pkg::MODE_NORM, 4'hf, 4'h3));
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         @(posedge clk);
         lat <= seed[3:0];
         @(posedge clk);
         #1;
         check({12'h000, pin_value}, {12'h000, lat});
         check({12'h000, pin_override}, 16'h0000);
      end
      $display("test port override done");

      for (int i = 0; i < 3; i++) begin
         start(sel_t[i], tmr_pkg::MODE_TOGL, 0, 16'hffff, a_t[i]);
         measure(0, 2 * ratio(sel_t[i]) * (int'(a_t[i]) + 1));
      end
      // Capture use is needed for an overrun to count as an error.
      wr(tmr_pkg::OFS_CTRL, ctrl(4'h0, tmr_pkg::MODE_TOGL, 4'h1, 4'h0) |
         (16'h0001 << tmr_pkg::CAPT_BIT));
      @(posedge clk);
      #1;
      check({15'h0000, req.ch[0]}, 16'h0001);
      check({15'h0000, ch_evt_cnt > 0}, 16'h0001);
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({15'h0000, req.err}, 16'h0001);
      check(16'(err_evt_cnt), 16'h0001);
      wr(tmr_pkg::OFS_COUNT, 16'h0000, 1'b1);
      wr(tmr_pkg::OFS_CMPB, 16'h0001, 1'b1);
      @(posedge clk);
      #1;
      check({15'h0000, req.wrap}, 16'h0000);
      check({15'h0000, req.err}, 16'h0001);
      check({15'h0000, req.ch[0]}, 16'h0001);
      wr(tmr_pkg::OFS_CMP, 16'h0001, 1'b1);
      @(posedge clk);
      #1;
      check({15'h0000, req.ch[0]}, 16'h0000);
      wr(tmr_pkg::OFS_FLAGS, 16'h00f7);
      $display("test toggle and flags done");

      start(4'h2, tmr_pkg::MODE_SGL, 1, 16'h0003, 16'h0001);
      measure(1, ratio(4'h2) * (3 + 1));
      for (int i = 0; i < 3; i++) begin
         start(4'h1, mode_t[i], 2, 16'h0004, 16'h0002);
         measure(2, 2 * 1 * 4);
         wr(tmr_pkg::OFS_CTRL, ctrl(4'h0, mode_t[i], 4'h0, 4'h0));
         @(posedge clk);
         #1;
         check({14'h0000, req.wrap, req.under}, 16'h0003);
         wr(tmr_pkg::OFS_FLAGS, 16'h00f7);
      end
      $display("test pwm done");

      wr(tmr_pkg::OFS_COUNT, 16'h0005);
      wr(tmr_pkg::OFS_CMD, 16'h0002);
      rd_chk(tmr_pkg::OFS_COUNT, 16'h0000);
      wr(tmr_pkg::OFS_TOPB, 16'h0009);
      rd_chk(tmr_pkg::OFS_TOPB, 16'h0009);
      wr(tmr_pkg::OFS_AUX, 16'h0001);
      wr(tmr_pkg::OFS_CMD, 16'h0001);
      rd_chk(tmr_pkg::OFS_TOP, 16'h0004);
      wr(tmr_pkg::OFS_AUX, 16'h0000);
      wr(tmr_pkg::OFS_CMD, 16'h0001);
      rd_chk(tmr_pkg::OFS_TOP, 16'h0009);
      wr(tmr_pkg::OFS_CTRL, ctrl(4'h1, tmr_pkg::MODE_NORM, 4'h0, 4'h0));
      rd_chk(tmr_pkg::OFS_CTRL, 16'h0001);
      wr(tmr_pkg::OFS_CMD, 16'h0004);
      rd_chk(tmr_pkg::OFS_TOP, 16'h0009);
      wr(tmr_pkg::OFS_CTRL, 16'h0000);
      wr(tmr_pkg::OFS_CMD, 16'h0004);
      rd_chk(tmr_pkg::OFS_TOP, 16'hffff);
      $display("test commands done");
      results();
   end
endmodule
